// *** pkg/cos_map.svh ***
// Constants of the operating-state controller: timing and handler numbers.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef COS_MAP_SVH
`define COS_MAP_SVH
`define COS_CLK_HZ          200000000
`define COS_SELFCHK_MS      1000
`define COS_OUTCLR_MAX_US   2000
`define COS_FLASH_MS        250
`define COS_HANDLER_BATT    5'h02
`define COS_HANDLER_COLD    5'h10
`define COS_HANDLER_NONE    5'h00
`endif

// *** pkg/cos_pkg.sv ***
// Types of the operating-state controller.
// Assumes nothing beyond a SystemVerilog compiler.
package cos_pkg;
  // Gray codes along start, run, conditional run, stop, halt.
  typedef enum logic [2:0] {
    COS_START = 3'h0,
    COS_RUN   = 3'h1,
    COS_CRUN  = 3'h3,
    COS_STOP  = 3'h2,
    COS_HALT  = 3'h6,
    COS_RESET = 3'h7
  } cos_state_e;
endpackage

// *** pkg/cos_tick_if.sv ***
// Interface carrying the divided tick pulses between controller and divider.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
interface cos_tick_if;
  logic msTick;
  logic flashTick;
  modport src (output msTick, output flashTick);
  modport dst (input msTick, input flashTick);
endinterface : cos_tick_if

// *** logic/cos_tick_div.sv ***
// Divider producing a millisecond tick and a lamp flash tick.
// Assumes clk_sys at the rate given in the constant header.
`timescale 1ns/100ps
`include "cos_map.svh"
module cos_tick_div #(
  parameter int CYC_PER_MS = `COS_CLK_HZ / 1000
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Tick outputs.
  cos_tick_if.src   tick
);
  localparam int FLASH_MS = `COS_FLASH_MS;

  initial begin
    if (CYC_PER_MS < 2) $error("CYC_PER_MS must be at least 2");
  end

  logic [31:0] cycCnt_r;
  logic [15:0] flashCnt_r;
  wire         msEnd    = (cycCnt_r == 32'(CYC_PER_MS - 1));
  wire         flashEnd = (flashCnt_r == 16'(FLASH_MS - 1));

  // A free-running divider; ticks are one-cycle enables.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cycCnt_r       <= 32'h0;
      flashCnt_r     <= 16'h0;
      tick.msTick    <= 1'b0;
      tick.flashTick <= 1'b0;
    end else begin
      cycCnt_r       <= msEnd ? 32'h0 : cycCnt_r + 32'h1;
      tick.msTick    <= msEnd;
      tick.flashTick <= msEnd && flashEnd;
      if (msEnd) begin
        flashCnt_r <= flashEnd ? 16'h0 : flashCnt_r + 16'h1;
      end
    end
  end
endmodule // cos_tick_div

// *** logic/cos_state_ctrl.sv ***
// Operating-state controller: state sequencing, lamps, switch handling.
// Notes on behaviour
// - Start state: one-second self-check, three lamps lit.
// - No programming unit: start leads to run.
// - Unmet breakpoint: conditional run, run lamp flashes.
// - Debugger active: stop state, lamps dark.
// - Errors, halt instruction, no program: halt.
// - Low supply or external reset: reset state.
// - Unhandled self-check fault: error lamp, keep running.
// - Battery fault lights lamp, calls handler 2.
// - Switch and clear honoured only when jumper enables.
// - Output-reset jumper enabled: halt clears outputs.
// - Output-reset jumper disabled: halt keeps outputs.
// - Enabled halt switch forces halt, beats debugger.
// - Switch halt-to-run: cold start, handler 16.
// - Clear held at switch-up zeroes non-register elements.
// - External reset: outputs low within 2 ms.
// - Reset release performs a cold start.
// - Low supply reset behaves as external reset.
// Assumes all inputs synchronous to clk_sys; levels unless noted as pulses.
`timescale 1ns/100ps
`include "cos_map.svh"
module cos_state_ctrl
  import cos_pkg::*;
#(
  parameter int SELFCHK_MS = `COS_SELFCHK_MS,
  parameter int CYC_PER_MS = `COS_CLK_HZ / 1000
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Supply monitor and reset terminal, active low.
  input  wire logic       supplyOk,
  input  wire logic       extReset_n,
  // Jumpers.
  input  wire logic       switchEnableJumper,
  input  wire logic       haltOutputResetJumper,
  // Front panel.
  input  wire logic       runHaltSwitchRun,
  input  wire logic       clearButton,
  // Programming unit and debugger.
  input  wire logic       progUnitAttached,
  input  wire logic       debuggerActive,
  input  wire logic       dbgRunCmd,
  input  wire logic       dbgStopCmd,
  input  wire logic       dbgRestartCmd,
  input  wire logic       breakpointSet,
  input  wire logic       breakpointHit,
  // Program status.
  input  wire logic       programLoaded,
  input  wire logic       seriousError,
  input  wire logic       hardwareError,
  input  wire logic       haltInstr,
  input  wire logic       selfChkFault,
  input  wire logic       faultHandlerPresent,
  input  wire logic       batteryFail,
  // Lamps.
  output logic            runLamp,
  output logic            haltLamp,
  output logic            errorLamp,
  output logic            battLamp,
  // Processor control.
  output cos_state_e      opState,
  output logic            execEnable,
  output logic            outputsClear,
  output logic            clearVolatile,
  output logic            clearAllButRegs,
  output logic            handlerCall,
  output logic [4:0]      handlerNum
);
  localparam int OUTCLR_MS = `COS_OUTCLR_MAX_US / 1000;

  initial begin
    if (SELFCHK_MS < 1) $error("SELFCHK_MS must be at least 1");
    // The check counter is 16 bits wide.
    if (SELFCHK_MS > 65536) $error("SELFCHK_MS too large for counter");
    if (OUTCLR_MS < 1) $error("output clear bound below one ms");
  end

  cos_tick_if tickBus ();

  // Millisecond and flash enables from one divider.
  cos_tick_div #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_div (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (tickBus.src)
  );

  cos_state_e  state_r, state_nxt;
  logic [15:0] chkCnt_r;
  logic        swRunPrev_r;
  logic        battPrev_r;
  logic        flash_r;
  logic        errLatch_r;
  logic        coldPend_r;
  logic        clearPend_r;

  // Input decoding as named wires.
  wire resetReq   = !supplyOk || !extReset_n;
  wire swActive   = switchEnableJumper;
  wire swHalt     = swActive && !runHaltSwitchRun;
  wire swUp       = swActive && runHaltSwitchRun && !swRunPrev_r;
  wire clrAtUp    = swUp && clearButton;
  wire haltCause  = seriousError || hardwareError || haltInstr
                    || !programLoaded;
  wire chkDone    = (chkCnt_r == 16'(SELFCHK_MS - 1))
                    && tickBus.msTick;
  wire inRunning  = (state_r == COS_RUN) || (state_r == COS_CRUN);
  wire errEvent   = inRunning && selfChkFault
                    && !faultHandlerPresent;
  wire battRise   = batteryFail && !battPrev_r;

  // Where to go after self-check or a debugger run command.
  function automatic cos_state_e run_target(input logic bpSet);
    run_target = bpSet ? COS_CRUN : COS_RUN;
  endfunction

  // Next state, priority: reset, halt switch, causes, debugger.
  always_comb begin
    state_nxt = state_r;
    if (resetReq) begin
      state_nxt = COS_RESET;
    end else if (state_r == COS_RESET) begin
      state_nxt = COS_START;
    end else if (swHalt) begin
      state_nxt = COS_HALT;
    end else if (swUp) begin
      state_nxt = COS_START;
    end else begin
      unique case (state_r)
        COS_START: begin
          if (chkDone) begin
            if (haltCause) begin
              state_nxt = COS_HALT;
            end else if (progUnitAttached && debuggerActive) begin
              state_nxt = COS_STOP;
            end else begin
              state_nxt = run_target(breakpointSet);
            end
          end
        end
        COS_RUN, COS_CRUN: begin
          if (haltCause) begin
            state_nxt = COS_HALT;
          end else if (progUnitAttached && debuggerActive
                       && (dbgStopCmd || breakpointHit)) begin
            state_nxt = COS_STOP;
          end else if (dbgRestartCmd && progUnitAttached) begin
            state_nxt = COS_START;
          end else begin
            state_nxt = run_target(breakpointSet);
          end
        end
        COS_STOP: begin
          if (!(progUnitAttached && debuggerActive)) begin
            state_nxt = run_target(breakpointSet);
          end else if (dbgRestartCmd) begin
            state_nxt = COS_START;
          end else if (dbgRunCmd) begin
            state_nxt = haltCause ? COS_HALT : run_target(breakpointSet);
          end
        end
        COS_HALT: begin
          if (progUnitAttached && dbgRestartCmd) begin
            state_nxt = COS_START;
          end
        end
        COS_RESET: begin
          state_nxt = COS_START;
        end
      endcase
    end
  end

  // State register and edge history.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r     <= COS_RESET;
      swRunPrev_r <= 1'b1;
      battPrev_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      swRunPrev_r <= runHaltSwitchRun;
      battPrev_r  <= batteryFail;
    end
  end

  // Self-check timer runs only in the start state.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state_r != COS_START) begin
      chkCnt_r <= 16'h0;
    end else if (tickBus.msTick && !chkDone) begin
      chkCnt_r <= chkCnt_r + 16'h1;
    end
  end

  // Flash phase for the run lamp in conditional run.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flash_r <= 1'b0;
    end else if (tickBus.flashTick) begin
      flash_r <= !flash_r;
    end
  end

  // Error lamp latch; a new fault wins over leaving run.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      errLatch_r <= 1'b0;
    end else if (errEvent) begin
      errLatch_r <= 1'b1;
    end else if (!inRunning) begin
      errLatch_r <= 1'b0;
    end
  end

  // Cold start pending: set on reset release or switch-up, cleared when the self-check ends.
  // Clear-all pending only from clear held at switch-up.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      coldPend_r  <= 1'b1;
      clearPend_r <= 1'b0;
    end else if (state_r == COS_RESET || swUp) begin
      coldPend_r  <= 1'b1;
      clearPend_r <= clrAtUp || (clearPend_r && !resetReq);
    end else if (chkDone) begin
      coldPend_r  <= 1'b0;
      clearPend_r <= 1'b0;
    end
  end

  // Lamp and control outputs, all registered.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      runLamp         <= 1'b1;
      haltLamp        <= 1'b1;
      errorLamp       <= 1'b1;
      battLamp        <= 1'b0;
      opState         <= COS_RESET;
      execEnable      <= 1'b0;
      outputsClear    <= 1'b1;
      clearVolatile   <= 1'b0;
      clearAllButRegs <= 1'b0;
      handlerCall     <= 1'b0;
      handlerNum      <= `COS_HANDLER_NONE;
    end else begin
      opState    <= state_nxt;
      battLamp   <= batteryFail;
      execEnable <= (state_nxt == COS_RUN) || (state_nxt == COS_CRUN);
      unique case (state_nxt)
        COS_START, COS_RESET: begin
          runLamp   <= 1'b1;
          haltLamp  <= 1'b1;
          errorLamp <= 1'b1;
        end
        COS_RUN: begin
          runLamp   <= 1'b1;
          haltLamp  <= 1'b0;
          errorLamp <= errLatch_r || errEvent;
        end
        COS_CRUN: begin
          runLamp   <= flash_r;
          haltLamp  <= 1'b0;
          errorLamp <= errLatch_r || errEvent;
        end
        COS_STOP: begin
          runLamp   <= 1'b0;
          haltLamp  <= 1'b0;
          errorLamp <= 1'b0;
        end
        COS_HALT: begin
          runLamp   <= 1'b0;
          haltLamp  <= 1'b1;
          errorLamp <= 1'b0;
        end
      endcase
      // Reset clears outputs the next cycle, well inside the 2 ms bound.
      outputsClear <= (state_nxt == COS_RESET)
                      || ((state_nxt == COS_HALT)
                          && haltOutputResetJumper);
      clearVolatile   <= chkDone && coldPend_r;
      clearAllButRegs <= chkDone && clearPend_r;
      // Cold-start handler wins over battery handler in the same cycle.
      if (chkDone && coldPend_r && state_nxt != COS_HALT) begin
        handlerCall <= 1'b1;
        handlerNum  <= `COS_HANDLER_COLD;
      end else if (battRise) begin
        handlerCall <= 1'b1;
        handlerNum  <= `COS_HANDLER_BATT;
      end else begin
        handlerCall <= 1'b0;
      end
    end
  end
endmodule // cos_state_ctrl

// *** dv/cos_state_ctrl_properties.sv ***
// Port assertions for the operating-state controller.
// Assumes it is bound to cos_state_ctrl; one clock domain.
`timescale 1ns/100ps
module cos_state_ctrl_properties
  import cos_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Inputs watched.
  input wire logic       supplyOk,
  input wire logic       extReset_n,
  input wire logic       switchEnableJumper,
  input wire logic       haltOutputResetJumper,
  input wire logic       runHaltSwitchRun,
  input wire logic       batteryFail,
  // Outputs watched.
  input wire logic       runLamp,
  input wire logic       haltLamp,
  input wire logic       errorLamp,
  input wire logic       battLamp,
  input wire cos_state_e opState,
  input wire logic       execEnable,
  input wire logic       outputsClear,
  input wire logic       clearVolatile,
  input wire logic       clearAllButRegs,
  input wire logic       handlerCall,
  input wire logic [4:0] handlerNum
);
  // Decoded requests; reset outranks the switch, so both are kept apart.
  wire [2:0] lamps  = {runLamp, haltLamp, errorLamp};
  wire       rstReq = !supplyOk || !extReset_n;
  wire       haltSw = switchEnableJumper && !runHaltSwitchRun;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // A cold start leaves the self-check straight into run.
  sequence leaveStart;
    opState == COS_START ##1 opState == COS_RUN;
  endsequence
  // Reset cause gone with no enabled halt switch pending.
  sequence resetGone;
    opState == COS_RESET && !rstReq && !haltSw;
  endsequence

  reset_entry_a: assert property (rstReq |=> opState == COS_RESET
    && outputsClear && lamps == 3'h7) else $error("reset state missed");
  reset_exit_a: assert property (resetGone |=> opState == COS_START)
    else $error("no cold start after reset");
  halt_switch_a: assert property (haltSw && !rstReq |=>
    opState == COS_HALT && lamps == 3'h2) else $error("switch halt missed");
  halt_outputs_a: assert property (opState == COS_HALT
    && $stable(haltOutputResetJumper) |-> outputsClear ==
    haltOutputResetJumper) else $error("halt output clearing wrong");
  start_lamps_a: assert property (opState == COS_START |-> lamps == 3'h7)
    else $error("start lamps wrong");
  stop_dark_a: assert property (opState == COS_STOP |-> lamps == 3'h0
    && !execEnable) else $error("stop not dark");
  exec_state_a: assert property (execEnable == (opState == COS_RUN
    || opState == COS_CRUN)) else $error("execution enable wrong");
  cold_call_a: assert property (leaveStart |-> handlerCall && clearVolatile
    && handlerNum == 5'h10) else $error("cold handler missed");
  clear_pair_a: assert property (clearAllButRegs |-> clearVolatile)
    else $error("full clear without cold clear");
  batt_lamp_a: assert property (batteryFail && !rstReq |=> battLamp)
    else $error("battery lamp dark");
endmodule // cos_state_ctrl_properties

bind cos_state_ctrl cos_state_ctrl_properties u_props (.*);

// *** dv/cos_panel_model.sv ***
// Front panel, jumpers and programming unit facing the controller.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module cos_panel_model (
  // Clock.
  input  wire logic clk_sys,
  // Jumpers and front panel.
  output logic      swEnable,
  output logic      outResetJmp,
  output logic      switchRun,
  output logic      clearBtn,
  // Programming unit.
  output logic      puAttached,
  output logic      dbgActive,
  output logic      runCmd,
  output logic      bpSet,
  output logic      bpHit
);
  // Power-up: jumpers off, switch in run, no unit plugged in.
  initial begin
    {swEnable, outResetJmp, switchRun, clearBtn} = 4'h2;
    {puAttached, dbgActive, runCmd, bpSet, bpHit} = 5'h00;
  end
  // Panel levels hold until changed, as a real switch does.
  task automatic setPanel(input logic [3:0] v);
    {swEnable, outResetJmp, switchRun, clearBtn} = v;
  endtask
  task automatic setUnit(input logic [3:0] v);
    {puAttached, dbgActive, bpSet, bpHit} = v;
  endtask
  // A debugger run command lasts exactly one clock.
  task automatic pulseRun();
    runCmd = 1'b1;
    @(posedge clk_sys);
    #1 runCmd = 1'b0;
  endtask
endmodule // cos_panel_model

// *** dv/cos_state_ctrl_tb.sv ***
// Self-checking bench for the operating-state controller.
// Assumes short self-check parameters; the panel model drives the switches.
`timescale 1ns/100ps
module cos_state_ctrl_tb;
  import cos_pkg::*;
  // Bench-driven status and observed outputs.
  logic       clk_sys, reset_n, supplyOk, extReset_n;
  logic [3:0] haltCause;
  logic       selfChkFault, batteryFail;
  logic       stopCmd, restartCmd, handlerPresent;
  logic       swEnable, outResetJmp, switchRun, clearBtn;
  logic       puAttached, dbgActive, runCmd, bpSet, bpHit;
  logic       runLamp, haltLamp, errorLamp, battLamp, execEnable;
  logic       outputsClear, clearVolatile, clearAllButRegs, handlerCall;
  cos_state_e opState;
  logic [4:0] handlerNum;
  int         badCount, checkCount, cycles;

  cos_panel_model panel (.clk_sys(clk_sys), .swEnable(swEnable),
    .outResetJmp(outResetJmp), .switchRun(switchRun), .clearBtn(clearBtn),
    .puAttached(puAttached), .dbgActive(dbgActive), .runCmd(runCmd),
    .bpSet(bpSet), .bpHit(bpHit));
  // Short counts keep the one-second check to under ten cycles.
  cos_state_ctrl #(.SELFCHK_MS(2), .CYC_PER_MS(4)) dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .supplyOk(supplyOk), .extReset_n(extReset_n),
    .switchEnableJumper(swEnable), .haltOutputResetJumper(outResetJmp),
    .runHaltSwitchRun(switchRun), .clearButton(clearBtn),
    .progUnitAttached(puAttached), .debuggerActive(dbgActive),
    .dbgRunCmd(runCmd), .dbgStopCmd(stopCmd), .dbgRestartCmd(restartCmd),
    .breakpointSet(bpSet), .breakpointHit(bpHit),
    .programLoaded(!haltCause[3]), .seriousError(haltCause[1]),
    .hardwareError(haltCause[2]), .haltInstr(haltCause[0]),
    .selfChkFault(selfChkFault), .faultHandlerPresent(handlerPresent),
    .batteryFail(batteryFail), .runLamp(runLamp), .haltLamp(haltLamp),
    .errorLamp(errorLamp), .battLamp(battLamp), .opState(opState),
    .execEnable(execEnable), .outputsClear(outputsClear),
    .clearVolatile(clearVolatile), .clearAllButRegs(clearAllButRegs),
    .handlerCall(handlerCall), .handlerNum(handlerNum));

  // Clock at 200 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Steps past an edge so its updates have landed before anything else.
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic look(input string what, cos_state_e st, logic [2:0] l);
    chk(what, {2'h0, st, l}, {2'h0, opState, runLamp, haltLamp, errorLamp});
  endtask
  // Bounded wait; a miss shows up in the following comparison.
  task automatic waitFor(input cos_state_e st);
    for (int n = 0; n < 40 && opState !== st; n++) tick();
  endtask
  task automatic coldRun();
    waitFor(COS_RUN);
    chk("cold", 8'h70, {1'b0, clearVolatile, handlerCall, handlerNum});
  endtask
  task automatic coldStart();
    panel.setPanel(4'h8);
    tick();
    panel.setPanel(4'ha);
    tick();
    coldRun();
  endtask
  task automatic testSwitch();
    panel.setPanel(4'h8);
    panel.setUnit(4'hc);
    tick();
    look("sw halt", COS_HALT, 3'h2);
    chk("halt keeps", 8'h0, {7'h0, outputsClear});
    panel.setPanel(4'hc);
    panel.setUnit(4'h0);
    tick(2);
    chk("halt clears", 8'h1, {7'h0, outputsClear});
    panel.setPanel(4'hf);
    tick();
    look("sw start", COS_START, 3'h7);
    panel.setPanel(4'ha);
    coldRun();
    chk("full clear", 8'h1, {7'h0, clearAllButRegs});
    panel.setPanel(4'h1);
    tick(3);
    look("sw ignored", COS_RUN, 3'h4);
    $display("switch test done");
  endtask
  task automatic testHalts();
    for (int i = 0; i < 4; i++) begin
      haltCause = 4'h1 << i;
      tick();
      look("halt cause", COS_HALT, 3'h2);
      haltCause = 4'h0;
      coldStart();
    end
    $display("halt cause test done");
  endtask
  task automatic testReset();
    for (int k = 0; k < 2; k++) begin
      {extReset_n, supplyOk} = k ? 2'h2 : 2'h1;
      tick();
      look("reset", COS_RESET, 3'h7);
      chk("reset clears", 8'h1, {7'h0, outputsClear});
      {extReset_n, supplyOk} = 2'h3;
      tick();
      look("restart", COS_START, 3'h7);
      coldRun();
    end
    $display("reset test done");
  endtask
  task automatic testDebug();
    panel.setUnit(4'hc);
    extReset_n = 1'b0;
    tick();
    extReset_n = 1'b1;
    tick();
    waitFor(COS_STOP);
    look("stop", COS_STOP, 3'h0);
    panel.setUnit(4'he);
    panel.pulseRun();
    chk("conditional_run_state", 8'h0c, {3'h0, opState, haltLamp, errorLamp});
    panel.setUnit(4'hf);
    tick();
    look("bp hit", COS_STOP, 3'h0);
    panel.setUnit(4'h0);
    tick();
    waitFor(COS_RUN);
    // A fault with its handler present must leave the error lamp dark.
    handlerPresent = 1'b1;
    selfChkFault = 1'b1;
    tick();
    look("handled fault", COS_RUN, 3'h4);
    handlerPresent = 1'b0;
    tick();
    selfChkFault = 1'b0;
    look("fault", COS_RUN, 3'h5);
    batteryFail = 1'b1;
    tick();
    chk("battery", 8'h62, {1'b0, battLamp, handlerCall, handlerNum});
    // Debugger stop, then restart back through the self-check.
    panel.setUnit(4'hc);
    stopCmd = 1'b1;
    tick();
    stopCmd = 1'b0;
    look("dbg stop", COS_STOP, 3'h0);
    restartCmd = 1'b1;
    tick();
    restartCmd = 1'b0;
    look("dbg restart", COS_START, 3'h7);
    waitFor(COS_STOP);
    look("restart stop", COS_STOP, 3'h0);
    $display("debug and fault test done");
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      badCount++;
      giveVerdict();
    end
  end
  // Main sequence.
  initial begin
    {reset_n, supplyOk, extReset_n, haltCause} = 7'h30;
    {selfChkFault, batteryFail} = 2'h0;
    {stopCmd, restartCmd, handlerPresent} = 3'h0;
    tick(3);
    reset_n = 1'b1;
    tick();
    look("start", COS_START, 3'h7);
    coldRun();
    look("run", COS_RUN, 3'h4);
    $display("power-up test done");
    testSwitch();
    testHalts();
    testReset();
    testDebug();
    giveVerdict();
  end
endmodule // cos_state_ctrl_tb
